/* src/rh_setpoint_regs.svh */
// constants for the humidity threshold setpoint output block
`ifndef RH_SETPOINT_REGS_SVH
`define RH_SETPOINT_REGS_SVH

// offset limits and default, tenths of a degree
`define OFFSET_MIN      (-10'sd300)
`define OFFSET_MAX      (10'sd300)
`define OFFSET_DEFAULT  (10'sd10)

// reference setpoint before any reception, tenths of a degree
`define REF_INIT_KELVIN     16'h0b72
`define REF_INIT_FAHRENHEIT 16'h02a8
`define REF_INIT_CELSIUS    16'h00c8

// repetition period limits and default, minutes
`define PERIOD_MIN      3'h1
`define PERIOD_MAX      3'h5
`define PERIOD_DEFAULT  3'h5

// timing: one second at a 20 ns clock
`define CLK_PERIOD_NS   20
`define SECOND_NS       1000000000
`define SECOND_CYCLES   (`SECOND_NS / `CLK_PERIOD_NS)
`define MINUTE_SECONDS  6'h3c

`endif

/* src/rh_setpoint_pkg.sv */
// types for the humidity threshold setpoint output block
package rh_setpoint_pkg;

  // temperature format of the 2-byte output value
  typedef enum logic [1:0] {
    FMT_CELSIUS,
    FMT_KELVIN,
    FMT_FAHRENHEIT
  } format_t;

  // action taken on a threshold condition
  typedef enum logic [1:0] {
    ACT_NONE,
    ACT_CURRENT,
    ACT_REFERENCE
  } action_t;

  // which threshold condition is active
  typedef enum logic [1:0] {
    COND_NONE,
    COND_FIRST,
    COND_SECOND
  } cond_t;

endpackage : rh_setpoint_pkg

/* src/rh_repeat_timer.sv */
// minute-based repetition timer for cyclic output sending
`timescale 1ns/1ps
`default_nettype none
`include "rh_setpoint_regs.svh"

module rh_repeat_timer #(
  parameter int SECOND_CYCLES = `SECOND_CYCLES
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // control
  input  wire logic       run,
  input  wire logic       restart,
  input  wire logic [2:0] period,
  // expiry pulse
  output logic            fire
);

  logic [31:0] tick;
  logic [31:0] next_tick;
  logic [5:0]  sec;
  logic [5:0]  next_sec;
  logic [2:0]  mins;
  logic [2:0]  next_mins;
  logic        next_fire;

  // prescaler to seconds, seconds to minutes, minutes to period
  always_comb begin
    next_tick = tick;
    next_sec  = sec;
    next_mins = mins;
    next_fire = 1'b0;
    if (!run || restart) begin
      next_tick = 32'h0;
      next_sec  = 6'h0;
      next_mins = 3'h0;
    end else if (tick == 32'(SECOND_CYCLES - 1)) begin
      next_tick = 32'h0;
      if (sec == `MINUTE_SECONDS - 6'h1) begin
        next_sec = 6'h0;
        if (mins == period - 3'h1) begin
          next_mins = 3'h0;
          next_fire = 1'b1;
        end else begin
          next_mins = mins + 3'h1;
        end
      end else begin
        next_sec = sec + 6'h1;
      end
    end else begin
      next_tick = tick + 32'h1;
    end
  end

  // timer registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick <= 32'h0;
      sec  <= 6'h0;
      mins <= 3'h0;
      fire <= 1'b0;
    end else if (ce) begin
      tick <= next_tick;
      sec  <= next_sec;
      mins <= next_mins;
      fire <= next_fire;
    end else begin
      fire <= 1'b0;
    end
  end

endmodule : rh_repeat_timer
`default_nettype wire

/* src/rh_threshold_setpoint_output.sv */
// humidity threshold output in 2-byte setpoint format
//
// Summary of operation
// - the offset is a signed count of tenths, held within -300..+300, reset to +10.
// - each condition picks no effect, current plus offset or reference plus offset; second defaults to none, first to current.
// - the current-setpoint action sends the own setpoint plus the offset.
// - the reference action sends the last received reference plus the offset.
// - in kelvin format the reference is 293 K until one is received.
// - in Fahrenheit format the reference is 68 F until one is received.
// - every bus or auxiliary voltage return issues a read request on the reference object.
// - output goes on read, on change of active condition, cyclically, and on voltage return if a condition occurred.
// - while disabled, condition telegrams are suppressed but threshold tracking goes on.
// - cyclic repetition is selectable and off after reset.
// - the repetition period is 1 to 5 minutes, 5 after reset.
// - in Celsius format the reference is 20 C until one is received.
`timescale 1ns/1ps
`default_nettype none
`include "rh_setpoint_regs.svh"

module rh_threshold_setpoint_output #(
  parameter int SECOND_CYCLES = `SECOND_CYCLES
) (
  // clock, reset, enable
  input  wire logic        SYS_CLK,
  input  wire logic        NRST,
  input  wire logic        CE,
  // configuration, taken on CFG_LOAD
  input  wire logic        CFG_LOAD,
  input  wire logic [1:0]  CFG_FORMAT,
  input  wire logic [1:0]  CFG_ACTION_FIRST,
  input  wire logic [1:0]  CFG_ACTION_SECOND,
  input  wire logic [9:0]  CFG_OFFSET,
  input  wire logic        CFG_REPEAT_EN,
  input  wire logic [2:0]  CFG_REPEAT_MIN,
  // threshold state
  input  wire logic        THRESH_ENABLE,
  input  wire logic        FIRST_THRESHOLD_CONDITION,
  input  wire logic        SECOND_THRESHOLD_CONDITION,
  // setpoints
  input  wire logic [15:0] CUR_SETPOINT,
  input  wire logic        REF_WRITE,
  input  wire logic [15:0] REF_VALUE,
  // bus events
  input  wire logic        OUT_READ,
  input  wire logic        VOLTAGE_RETURN,
  // output telegram and reference read request
  output logic             SEND_STB,
  output logic [15:0]      SEND_VALUE,
  output logic             REF_READ_REQ,
  // status
  output logic [1:0]       ACTIVE_COND
);

  // clamp an offset into the legal range
  function automatic logic [9:0] clamp_offset(input logic [9:0] v);
    if ($signed(v) < `OFFSET_MIN) begin
      clamp_offset = `OFFSET_MIN;
    end else if ($signed(v) > `OFFSET_MAX) begin
      clamp_offset = `OFFSET_MAX;
    end else begin
      clamp_offset = v;
    end
  endfunction : clamp_offset

  // clamp a period into whole minutes 1..5
  function automatic logic [2:0] clamp_period(input logic [2:0] v);
    if (v < `PERIOD_MIN) begin
      clamp_period = `PERIOD_MIN;
    end else if (v > `PERIOD_MAX) begin
      clamp_period = `PERIOD_MAX;
    end else begin
      clamp_period = v;
    end
  endfunction : clamp_period

  // initial reference for each format
  function automatic logic [15:0] ref_init(input logic [1:0] f);
    case (f)
      rh_setpoint_pkg::FMT_KELVIN:     ref_init = `REF_INIT_KELVIN;
      rh_setpoint_pkg::FMT_FAHRENHEIT: ref_init = `REF_INIT_FAHRENHEIT;
      default:                         ref_init = `REF_INIT_CELSIUS;
    endcase
  endfunction : ref_init

  // configuration state
  rh_setpoint_pkg::format_t format;
  rh_setpoint_pkg::format_t next_format;
  rh_setpoint_pkg::action_t act_first;
  rh_setpoint_pkg::action_t next_act_first;
  rh_setpoint_pkg::action_t act_second;
  rh_setpoint_pkg::action_t next_act_second;
  logic [9:0]               offset;
  logic [9:0]               next_offset;
  logic                     repeat_en;
  logic                     next_repeat_en;
  logic [2:0]               period;
  logic [2:0]               next_period;

  // configuration: reset defaults, clamped load
  always_comb begin
    next_format     = format;
    next_act_first  = act_first;
    next_act_second = act_second;
    next_offset     = offset;
    next_repeat_en  = repeat_en;
    next_period     = period;
    if (CFG_LOAD) begin
      next_format     = rh_setpoint_pkg::format_t'(CFG_FORMAT);
      next_act_first  = rh_setpoint_pkg::action_t'(CFG_ACTION_FIRST);
      next_act_second = rh_setpoint_pkg::action_t'(CFG_ACTION_SECOND);
      next_offset     = clamp_offset(CFG_OFFSET);
      next_repeat_en  = CFG_REPEAT_EN;
      next_period     = clamp_period(CFG_REPEAT_MIN);
    end
  end

  // configuration registers
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      format     <= rh_setpoint_pkg::FMT_KELVIN;
      act_first  <= rh_setpoint_pkg::ACT_CURRENT;
      act_second <= rh_setpoint_pkg::ACT_NONE;
      offset     <= `OFFSET_DEFAULT;
      repeat_en  <= 1'b0;
      period     <= `PERIOD_DEFAULT;
    end else if (CE) begin
      format     <= next_format;
      act_first  <= next_act_first;
      act_second <= next_act_second;
      offset     <= next_offset;
      repeat_en  <= next_repeat_en;
      period     <= next_period;
    end
  end

  // reference and condition state
  logic [15:0]            ref_value;
  logic [15:0]            next_ref_value;
  logic                   ref_seen;
  logic                   next_ref_seen;
  rh_setpoint_pkg::cond_t cond;
  rh_setpoint_pkg::cond_t next_cond;
  logic                   changed;

  // reference capture and active condition tracking
  always_comb begin
    next_ref_value = ref_value;
    next_ref_seen  = ref_seen;
    next_cond      = cond;
    if (REF_WRITE) begin
      next_ref_value = REF_VALUE;
      next_ref_seen  = 1'b1;
    end
    // tracking runs even while disabled
    if (SECOND_THRESHOLD_CONDITION) begin
      next_cond = rh_setpoint_pkg::COND_SECOND;
    end else if (FIRST_THRESHOLD_CONDITION) begin
      next_cond = rh_setpoint_pkg::COND_FIRST;
    end
  end

  assign changed = (next_cond != cond);

  // reference and condition registers
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      ref_value <= 16'h0000;
      ref_seen  <= 1'b0;
      cond      <= rh_setpoint_pkg::COND_NONE;
    end else if (CE) begin
      ref_value <= next_ref_value;
      ref_seen  <= next_ref_seen;
      cond      <= next_cond;
    end
  end

  // cyclic repetition timer, restarted by every telegram
  logic fire;
  logic sent;

  rh_repeat_timer #(
    .SECOND_CYCLES (SECOND_CYCLES)
  ) u_timer (
    .clk     (SYS_CLK),
    .rst_n   (NRST),
    .ce      (CE),
    .run     (repeat_en),
    .restart (sent),
    .period  (period),
    .fire    (fire)
  );

  // value and trigger selection
  rh_setpoint_pkg::action_t act;
  logic [15:0]              base;
  logic [15:0]              value;
  logic                     want;
  logic                     next_stb;
  logic                     next_req;
  logic [15:0]              next_value;

  always_comb begin
    case (next_cond)
      rh_setpoint_pkg::COND_FIRST:  act = act_first;
      rh_setpoint_pkg::COND_SECOND: act = act_second;
      default:                      act = rh_setpoint_pkg::ACT_NONE;
    endcase
    if (act == rh_setpoint_pkg::ACT_REFERENCE) begin
      base = next_ref_seen ? next_ref_value : ref_init(format);
    end else begin
      base = CUR_SETPOINT;
    end
    value = base + {{6{offset[9]}}, offset};
    // read answered regardless of the enable; spontaneous sends need the enable
    want = OUT_READ
         | (THRESH_ENABLE & changed)
         | (THRESH_ENABLE & fire & repeat_en)
         | (THRESH_ENABLE & VOLTAGE_RETURN);
    next_stb   = want && (act != rh_setpoint_pkg::ACT_NONE);
    next_value = next_stb ? value : SEND_VALUE;
    next_req   = VOLTAGE_RETURN;
  end

  assign sent        = next_stb; // restart on the telegram's own edge
  assign ACTIVE_COND = cond;

  // output registers
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      SEND_STB     <= 1'b0;
      SEND_VALUE   <= 16'h0000;
      REF_READ_REQ <= 1'b0;
    end else if (CE) begin
      SEND_STB     <= next_stb;
      SEND_VALUE   <= next_value;
      REF_READ_REQ <= next_req;
    end
  end

endmodule : rh_threshold_setpoint_output
`default_nettype wire

/* testbench/rh_setpoint_sva.sv */
// port assertions for the humidity threshold setpoint output block
`timescale 1ns/1ps
`default_nettype none
module rh_setpoint_sva (
  // clock, reset, enable
  input wire logic        SYS_CLK,
  input wire logic        NRST,
  input wire logic        CE,
  // threshold state and bus events
  input wire logic        THRESH_ENABLE,
  input wire logic        FIRST_THRESHOLD_CONDITION,
  input wire logic        SECOND_THRESHOLD_CONDITION,
  input wire logic        OUT_READ,
  input wire logic        VOLTAGE_RETURN,
  // outputs
  input wire logic        SEND_STB,
  input wire logic [15:0] SEND_VALUE,
  input wire logic        REF_READ_REQ,
  input wire logic [1:0]  ACTIVE_COND
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);

  // reference read request follows each voltage return
  a_vret_request: assert property (CE && VOLTAGE_RETURN |=> REF_READ_REQ)
    else $error("no reference read after voltage return");
  a_request_cause: assert property (REF_READ_REQ && $past(CE) |->
    $past(VOLTAGE_RETURN)) else $error("reference read without cause");
  a_request_pulse: assert property (CE && REF_READ_REQ && !VOLTAGE_RETURN
    |=> !REF_READ_REQ) else $error("reference read longer than a cycle");
  // sent value only moves with a telegram
  a_value_hold: assert property (!SEND_STB |-> $stable(SEND_VALUE))
    else $error("output value moved without telegram");
  a_send_cond: assert property (SEND_STB |-> ACTIVE_COND != 2'h0)
    else $error("telegram with no condition");
  // condition tracking goes on even while disabled
  a_second_wins: assert property (CE && SECOND_THRESHOLD_CONDITION
    |=> ACTIVE_COND == 2'h2) else $error("second condition not taken");
  a_first_taken: assert property (CE && FIRST_THRESHOLD_CONDITION &&
    !SECOND_THRESHOLD_CONDITION |=> ACTIVE_COND == 2'h1)
    else $error("first condition not taken");
  a_quiet_disabled: assert property (SEND_STB && $past(CE) &&
    !$past(OUT_READ) |-> $past(THRESH_ENABLE))
    else $error("spontaneous telegram while disabled");

  c_read: cover property (SEND_STB && $past(OUT_READ));
  c_spont: cover property (SEND_STB && !$past(OUT_READ));
  c_request: cover property (REF_READ_REQ);
endmodule : rh_setpoint_sva

bind rh_threshold_setpoint_output rh_setpoint_sva u_sva (.SYS_CLK, .NRST,
  .CE, .THRESH_ENABLE, .FIRST_THRESHOLD_CONDITION,
  .SECOND_THRESHOLD_CONDITION, .OUT_READ, .VOLTAGE_RETURN, .SEND_STB,
  .SEND_VALUE, .REF_READ_REQ, .ACTIVE_COND);
`default_nettype wire

/* testbench/rh_bus_peer.sv */
// far-side bus device answering reference read requests
`timescale 1ns/1ps
`default_nettype none
module rh_bus_peer #(
  parameter int          DELAY  = 3,
  parameter logic [15:0] ANSWER = 16'h0100
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // read request from the device
  input  wire logic        req,
  // answer on the reference object
  output logic             ref_write,
  output logic [15:0]      ref_value
);
  int cnt;

  // answer a request after a fixed delay, one pulse
  always @(negedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= -1;
      ref_write <= 1'b0;
    end else begin
      ref_write <= (cnt == 0);
      if (req) cnt <= DELAY;
      else if (cnt >= 0) cnt <= cnt - 1;
    end
  end

  // a released line shows the inverse of the answer
  assign ref_value = ref_write ? ANSWER : ~ANSWER;
endmodule : rh_bus_peer
`default_nettype wire

/* testbench/tb_top.sv */
// self-checking bench for the setpoint output block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int SEC = 2;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        cfg_load = 1'b0;
  logic [1:0]  fmt = 2'h1;
  logic [1:0]  act1 = 2'h1;
  logic [1:0]  act2 = 2'h0;
  logic [9:0]  offset = 10'h00a;
  logic        rep_en = 1'b0;
  logic [2:0]  rep_min = 3'h5;
  logic        en = 1'b1;
  logic        first_cond = 1'b0;
  logic        second_cond = 1'b0;
  logic [15:0] cur = 16'h00c8;
  logic        rd = 1'b0;
  logic        vret = 1'b0;
  logic        ref_wr;
  logic [15:0] ref_val;
  logic        stb;
  logic        rreq;
  logic [15:0] val;
  logic [1:0]  cond;
  int          errors = 0;
  int          n_checks = 0;
  int          n;

  always #10 clk = ~clk;

  rh_threshold_setpoint_output #(.SECOND_CYCLES(SEC)) u_dut (.SYS_CLK(clk),
    .NRST(nrst), .CE(1'b1), .CFG_LOAD(cfg_load), .CFG_FORMAT(fmt),
    .CFG_ACTION_FIRST(act1), .CFG_ACTION_SECOND(act2), .CFG_OFFSET(offset),
    .CFG_REPEAT_EN(rep_en), .CFG_REPEAT_MIN(rep_min), .THRESH_ENABLE(en),
    .FIRST_THRESHOLD_CONDITION(first_cond),
    .SECOND_THRESHOLD_CONDITION(second_cond), .CUR_SETPOINT(cur),
    .REF_WRITE(ref_wr), .REF_VALUE(ref_val), .OUT_READ(rd),
    .VOLTAGE_RETURN(vret), .SEND_STB(stb), .SEND_VALUE(val),
    .REF_READ_REQ(rreq), .ACTIVE_COND(cond));

  rh_bus_peer u_peer (.clk(clk), .rst_n(nrst), .req(rreq),
    .ref_write(ref_wr), .ref_value(ref_val));

  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // load a configuration, one cycle strobe
  task automatic load(input logic [1:0] f, a1, a2, input logic [9:0] o,
                      input logic re, input logic [2:0] rm);
    fmt = f;
    act1 = a1;
    act2 = a2;
    offset = o;
    rep_en = re;
    rep_min = rm;
    cfg_load = 1'b1;
    @(negedge clk);
    cfg_load = 1'b0;
  endtask : load

  // idle edge, pulse events {read, vret, first, second}, check telegram
  task automatic fire(input logic [3:0] ev, input logic es,
                      input logic [15:0] ev_val);
    @(negedge clk);
    {rd, vret, first_cond, second_cond} = ev;
    @(negedge clk);
    {rd, vret, first_cond, second_cond} = 4'h0;
    check(16'(stb), 16'(es));
    if (es) check(val, ev_val);
  endtask : fire

  // count cycles until a telegram, bounded
  task automatic wait_send(input int lim, output int cnt);
    @(negedge clk);
    cnt = 1;
    while (stb !== 1'b1 && cnt < lim) begin
      @(negedge clk);
      cnt++;
    end
  endtask : wait_send

  // verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  // watchdog
  initial begin
    #(20 * 6000);
    errors++;
    complete_run();
  end

  // test sequence
  initial begin
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    check({13'h0, stb, cond}, 16'h0);
    check(val, 16'h0);
    fire(4'h8, 1'b0, 16'h0);
    $display("end of test 1");
    fire(4'h2, 1'b1, 16'h00d2);
    fire(4'h1, 1'b0, 16'h0);
    check(16'(cond), 16'h2);
    fire(4'h8, 1'b0, 16'h0);
    $display("end of test 2");
    load(2'h1, 2'h2, 2'h0, 10'h2d4, 1'b0, 3'h5);
    fire(4'h2, 1'b1, 16'h0a46);
    load(2'h2, 2'h2, 2'h0, 10'h2d4, 1'b0, 3'h5);
    fire(4'h8, 1'b1, 16'h017c);
    load(2'h0, 2'h2, 2'h0, 10'h190, 1'b0, 3'h5);
    fire(4'h8, 1'b1, 16'h01f4);
    load(2'h0, 2'h2, 2'h0, 10'h26c, 1'b0, 3'h5);
    fire(4'h8, 1'b1, 16'hff9c);
    $display("end of test 3");
    fire(4'h4, 1'b1, 16'hff9c);
    check(16'(rreq), 16'h1);
    repeat (8) @(negedge clk);
    fire(4'h8, 1'b1, 16'hffd4);
    $display("end of test 4");
    load(2'h0, 2'h2, 2'h1, 10'h00a, 1'b0, 3'h5);
    en = 1'b0;
    fire(4'h1, 1'b0, 16'h0);
    check(16'(cond), 16'h2);
    fire(4'h4, 1'b0, 16'h0);
    fire(4'h8, 1'b1, 16'h00d2);
    en = 1'b1;
    $display("end of test 5");
    wait_send(650, n);
    check(16'(n), 16'h028a);
    load(2'h0, 2'h2, 2'h1, 10'h00a, 1'b1, 3'h0);
    wait_send(250, n);
    check(16'(stb), 16'h1);
    check(val, 16'h00d2);
    wait_send(250, n);
    check(16'(n == 60 * SEC || n == 60 * SEC + 1), 16'h1);
    $display("end of test 6");
    // period above range is held at five minutes
    load(2'h0, 2'h2, 2'h1, 10'h00a, 1'b1, 3'h7);
    wait_send(700, n);
    check(16'(n == 5 * 60 * SEC), 16'h1);
    check(val, 16'h00d2);
    $display("end of test 7");
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
